// ==== cache_coherence_op_control_test.sv ====
// self-checking bench: core and engine joined, driven over AXI4-Lite
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module cache_coherence_op_control_test;
    logic        CLK = 1'b0, SRST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        hold_seen, irq_off, IRQ_EN, MEM_GRANT, ALLOC_HOLD, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [5:0]  AWADDR = 6'h0, ARADDR = 6'h0;
    logic [3:0]  WSTRB = 4'h0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [1:0]  BRESP, RRESP;
    int          compares = 0, miscompares = 0;
    cc_if bus();
    cc_core i_cc_core (.CLK(CLK), .SRST(SRST), .bus(bus), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .IRQ_EN(IRQ_EN), .MEM_REQ(1'b1), .MEM_GRANT(MEM_GRANT));
    cc_engine #(.NUM_SETS(4)) i_cc_engine (.CLK(CLK), .SRST(SRST), .bus(bus), .CMD_VALID(), .CMD_READY(2'h3),
        .CMD_GLOBAL(), .CMD_OP(), .CMD_ADDR(), .CMD_SET(), .ALLOC_HOLD(ALLOC_HOLD));
    cc_chk i_cc_chk (.CLK(CLK), .SRST(SRST), .rq_valid(bus.rq_valid), .rq_ready(bus.rq_ready),
        .rq_write(bus.rq_write), .rq_index(bus.rq_index), .rq_wdata(bus.rq_wdata), .rs_valid(bus.rs_valid),
        .rs_rdata(bus.rs_rdata), .fence_req(bus.fence_req), .fence_done(bus.fence_done));
    initial forever #10 CLK = ~CLK;
    always @(posedge CLK) begin
        hold_seen <= ALLOC_HOLD | hold_seen & ~AWVALID;
        irq_off <= !IRQ_EN && !MEM_GRANT || irq_off && !AWVALID;
    end
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ready sampled at negedge so the edge is not raced
    task automatic xfer(input bit w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
                        output logic [1:0] r);
        bit pa, pw, pr;
        @(posedge CLK);
        if (w) begin AWADDR <= a; WDATA <= d; WSTRB <= 4'hf; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1; end
        else begin ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1; end
        for (int n = 0; n < 50; n++) begin
            @(negedge CLK);
            pa = w ? AWVALID && AWREADY : ARVALID && ARREADY;
            pw = WVALID && WREADY;
            pr = w ? BVALID : RVALID;
            q = RDATA;
            r = w ? BRESP : RRESP;
            @(posedge CLK);
            if (pa) begin AWVALID <= 1'b0; ARVALID <= 1'b0; end
            if (pw) WVALID <= 1'b0;
            if (pr) begin BREADY <= 1'b0; RREADY <= 1'b0; return; end
        end
        miscompares++;
        print_verdict;
    endtask
    task automatic wait_idle(output logic [31:0] q);
        logic [1:0] r;
        for (int n = 0; n < 300; n++) begin
            xfer(1'b0, cc_pkg::A_STATUS, 32'h0, q, r);
            if (q[0] === 1'b0) return;
        end
        miscompares++;
        print_verdict;
    endtask
    task automatic t_ops;
        logic [31:0] q;
        logic [1:0]  r;
        for (int c = 0; c < 2; c++) for (int o = 0; o < 3; o++)
            for (int g = 0; g < 2; g++) for (int p = 0; p < 2; p++) begin
            xfer(1'b1, cc_pkg::A_ADDR, 32'h1000, q, r);
            xfer(1'b1, cc_pkg::A_COUNT, 32'h40, q, r);
            xfer(1'b1, cc_pkg::A_CTRL, 32'({p[0], o[1:0], c[0], g[0], 1'b1}), q, r);
            wait_idle(q);
            `CHK(q, 32'h2)
            `CHK(irq_off, 1'b1)
            `CHK(hold_seen, o != 0)
        end
    endtask
    task automatic t_refuse;
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b1, cc_pkg::A_COUNT, 32'h3000, q, r);
        xfer(1'b1, cc_pkg::A_CTRL, 32'h9, q, r);
        xfer(1'b1, cc_pkg::A_CTRL, 32'h9, q, r);
        xfer(1'b0, cc_pkg::A_STATUS, 32'h0, q, r);
        `CHK(q[2:0], 3'h5)
        xfer(1'b1, cc_pkg::A_STATUS, 32'h4, q, r);
        wait_idle(q);
        `CHK(q, 32'h2)
    endtask
    task automatic t_unmapped;
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b0, 6'h10, 32'h0, q, r);
        `CHK({r, q}, {cc_pkg::RESP_SLVERR, 32'h0})
        xfer(1'b1, 6'h10, 32'h1, q, r);
        `CHK(r, cc_pkg::RESP_SLVERR)
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        t_ops;
        t_refuse;
        t_unmapped;
        print_verdict;
    end
endmodule

// ==== cc_chk.sv ====
// concurrent checks on the coherence command link
`timescale 1ns/1ns
module cc_chk (
    input wire logic        CLK,        // clock
    input wire logic        SRST,       // reset
    input wire logic        rq_valid,   // request
    input wire logic        rq_ready,   // taken
    input wire logic        rq_write,   // write
    input wire logic [3:0]  rq_index,   // index
    input wire logic [31:0] rq_wdata,   // data
    input wire logic        rs_valid,   // answer
    input wire logic [31:0] rs_rdata,   // answer data
    input wire logic        fence_req,  // fence wait
    input wire logic        fence_done  // all idle
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire rd = rq_valid && !rq_write;
    sequence s_launch;
        rq_valid && rq_ready && rq_write && (rq_index inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
            && rq_wdata[15:0] != 16'h0 || rq_index inside {[4'h8:4'hd]} && rq_wdata[0]);
    endsequence
    a_launch_busy: assert property (s_launch |=> !fence_done) else $error("launch left engine idle");
    a_read_answer: assert property (rd |=> rs_valid) else $error("read unanswered");
    a_answer_cause: assert property (rs_valid |-> $past(rd)) else $error("answer without read");
    a_count_idle: assert property (rd && fence_done && rq_index inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
        |=> rs_rdata[15:0] == 16'h0) else $error("idle count not zero");
    a_trig_idle: assert property (rd && fence_done && rq_index inside {[4'h8:4'hd]} |=> !rs_rdata[0])
        else $error("idle trigger bit set");
    a_write_idle: assert property (!fence_done |-> !(rq_valid && rq_write)) else $error("write while busy");
    a_fence_quiet: assert property (fence_req && !fence_done |-> !rq_valid) else $error("request in fence");
    a_done_bound: assert property ($fell(fence_done) |-> ##[1:1000] fence_done) else $error("op never done");
endmodule

// ==== cc_core.sv ====
// issuing core end: takes orders over AXI4-Lite and runs the safe coherence sequence
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module cc_core (
    input  wire logic                      CLK,       // core clock
    input  wire logic                      SRST,      // synchronous reset, active high
    cc_if.core                             bus,       // command link to the engine
    input  wire logic [cc_pkg::AXI_AW-1:0] AWADDR,    // write address
    input  wire logic                      AWVALID,   // write address valid
    output logic                           AWREADY,   // write address ready
    input  wire logic [31:0]               WDATA,     // write data
    input  wire logic [3:0]                WSTRB,     // byte strobes
    input  wire logic                      WVALID,    // write data valid
    output logic                           WREADY,    // write data ready
    output logic      [1:0]                BRESP,     // write response
    output logic                           BVALID,    // write response valid
    input  wire logic                      BREADY,    // write response ready
    input  wire logic [cc_pkg::AXI_AW-1:0] ARADDR,    // read address
    input  wire logic                      ARVALID,   // read address valid
    output logic                           ARREADY,   // read address ready
    output logic      [31:0]               RDATA,     // read data
    output logic      [1:0]                RRESP,     // read response
    output logic                           RVALID,    // read data valid
    input  wire logic                      RREADY,    // read data ready
    output logic                           IRQ_EN,    // interrupt enable of the core
    input  wire logic                      MEM_REQ,   // core wants a memory access
    output logic                           MEM_GRANT  // memory access allowed
);
    typedef enum logic [6:0] {
        S_IDLE    = 7'b0000001,
        S_IRQ_OFF = 7'b0000010,
        S_BAR     = 7'b0000100,
        S_LAUNCH  = 7'b0001000,
        S_WAIT    = 7'b0010000,
        S_POLL    = 7'b0100000,
        S_NOPS    = 7'b1000000
    } seq_e;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    seq_e        st_q, st_d;
    logic        glb_q, glb_d, cache_q, cache_d, poll_q, poll_d;
    logic [1:0]  op_q, op_d;
    logic [31:0] addr_q, addr_d, count_q, count_d;
    logic [cc_pkg::NOP_W-1:0] nop_q, nop_d;
    logic        irq_q, irq_d, refused_q, refused_d;
    logic        rqv_q, rqv_d, rqw_q, rqw_d;
    logic [cc_pkg::IDX_W-1:0] rqi_q, rqi_d;
    logic [31:0] rqd_q, rqd_d;
    logic        awg_q, awg_d, wg_q, wg_d, bv_q, bv_d, rv_q, rv_d;
    logic [cc_pkg::AXI_AW-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [cc_pkg::IDX_W-1:0] bar_idx, launch_idx;
    logic        done_seen;

    assign bar_idx    = cache_q ? cc_pkg::IDX_BAR_L2 : cc_pkg::IDX_BAR_L1;
    assign launch_idx = glb_q ? 4'((cache_q ? cc_pkg::IDX_GLB_L2 : cc_pkg::IDX_GLB_L1) + {2'h0, op_q})
                              : 4'(bar_idx + 4'h1 + {2'h0, op_q});
    assign done_seen  = glb_q ? ~bus.rs_rdata[cc_pkg::TRIG_BIT] : bus.rs_rdata[cc_pkg::WC_W-1:0] == '0;

    always_comb begin
        st_d = st_q; glb_d = glb_q; cache_d = cache_q; poll_d = poll_q; op_d = op_q;
        addr_d = addr_q; count_d = count_q; nop_d = nop_q; irq_d = irq_q; refused_d = refused_q;
        rqw_d = rqw_q; rqi_d = rqi_q; rqd_d = rqd_q;
        rqv_d = rqv_q & ~bus.rq_ready;
        awg_d = awg_q; wg_d = wg_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
        bv_d = bv_q & ~BREADY; br_d = br_q; rv_d = rv_q & ~RREADY; rd_d = rd_q; rr_d = rr_q;
        // AXI4-Lite slave: address and data taken in either order, answered when both are in
        if (AWVALID && AWREADY) begin
            awg_d = 1'b1;
            awa_d = AWADDR;
        end
        if (WVALID && WREADY) begin
            wg_d = 1'b1;
            wd_d = WDATA;
            ws_d = WSTRB;
        end
        if (awg_q && wg_q && !bv_q) begin
            awg_d = 1'b0;
            wg_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = cc_pkg::RESP_OKAY;
            case (awa_q)
                cc_pkg::A_CTRL: begin
                    if (ws_q[0] && wd_q[cc_pkg::CTRL_GO]) begin
                        if (st_q == S_IDLE) begin
                            glb_d   = wd_q[cc_pkg::CTRL_GLOBAL];
                            cache_d = wd_q[cc_pkg::CTRL_CACHE];
                            op_d    = wd_q[cc_pkg::CTRL_OP_LSB +: 2];
                            poll_d  = wd_q[cc_pkg::CTRL_POLL];
                            st_d    = S_IRQ_OFF;
                        end else begin
                            refused_d = 1'b1;
                        end
                    end
                end
                cc_pkg::A_ADDR:   addr_d  = (st_q == S_IDLE) ? merge(addr_q, wd_q, ws_q) : addr_q;
                cc_pkg::A_COUNT:  count_d = (st_q == S_IDLE) ? merge(count_q, wd_q, ws_q) : count_q;
                cc_pkg::A_STATUS: refused_d = (ws_q[0] && wd_q[cc_pkg::ST_REFUSED]) ? 1'b0 : refused_d;
                default:          br_d = cc_pkg::RESP_SLVERR;
            endcase
        end
        if (ARVALID && ARREADY) begin
            rv_d = 1'b1;
            rr_d = cc_pkg::RESP_OKAY;
            rd_d = '0;
            case (ARADDR)
                cc_pkg::A_CTRL: begin
                    rd_d[cc_pkg::CTRL_GLOBAL]       = glb_q;
                    rd_d[cc_pkg::CTRL_CACHE]        = cache_q;
                    rd_d[cc_pkg::CTRL_OP_LSB +: 2]  = op_q;
                    rd_d[cc_pkg::CTRL_POLL]         = poll_q;
                end
                cc_pkg::A_ADDR:   rd_d = addr_q;
                cc_pkg::A_COUNT:  rd_d = count_q;
                cc_pkg::A_STATUS: begin
                    rd_d[cc_pkg::ST_BUSY]    = st_q != S_IDLE;
                    rd_d[cc_pkg::ST_IRQ_EN]  = irq_q;
                    rd_d[cc_pkg::ST_REFUSED] = refused_q;
                end
                default: rr_d = cc_pkg::RESP_SLVERR;
            endcase
        end
        case (st_q)
            S_IDLE: begin
                irq_d = 1'b1;
                if (st_d == S_IRQ_OFF) begin
                    irq_d = 1'b0; // R04
                end
            end
            S_IRQ_OFF: begin
                rqv_d = 1'b1;
                rqw_d = 1'b1;
                if (glb_q) begin
                    rqi_d = launch_idx;
                    rqd_d = 32'h1 << cc_pkg::TRIG_BIT; // R06
                    st_d  = S_LAUNCH;
                end else begin
                    rqi_d = bar_idx;
                    rqd_d = addr_q; // R04
                    st_d  = S_BAR;
                end
            end
            S_BAR: begin
                if (bus.rq_ready) begin
                    rqv_d = 1'b1;
                    rqi_d = launch_idx;
                    rqd_d = {{(32 - cc_pkg::WC_W){1'b0}}, count_q[cc_pkg::WC_W-1:0]}; // R05
                    st_d  = S_LAUNCH;
                end
            end
            S_LAUNCH: begin
                if (bus.rq_ready) begin
                    st_d = poll_q ? S_POLL : S_WAIT;
                    if (poll_q) begin
                        rqv_d = 1'b1;
                        rqw_d = 1'b0;
                    end
                end
            end
            S_WAIT: begin
                if (bus.fence_done) begin
                    st_d  = S_NOPS; // R08
                    nop_d = '0;
                end
            end
            S_POLL: begin
                if (bus.rs_valid) begin
                    if (done_seen) begin
                        st_d  = S_NOPS; // R08
                        nop_d = '0;
                    end else begin
                        rqv_d = 1'b1;
                    end
                end
            end
            S_NOPS: begin
                nop_d = nop_q + cc_pkg::NOP_W'(1);
                if (nop_q == cc_pkg::NOP_W'(cc_pkg::NOP_CYCLES - 1)) begin
                    st_d  = S_IDLE;
                    irq_d = 1'b1; // R08
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_q <= S_IDLE; glb_q <= 1'b0; cache_q <= 1'b0; poll_q <= 1'b0; op_q <= cc_pkg::OP_WB;
            addr_q <= '0; count_q <= '0; nop_q <= '0; irq_q <= 1'b1; refused_q <= 1'b0;
            rqv_q <= 1'b0; rqw_q <= 1'b0; rqi_q <= '0; rqd_q <= '0;
            awg_q <= 1'b0; wg_q <= 1'b0; awa_q <= '0; wd_q <= '0; ws_q <= '0;
            bv_q <= 1'b0; br_q <= cc_pkg::RESP_OKAY; rv_q <= 1'b0; rd_q <= '0; rr_q <= cc_pkg::RESP_OKAY;
        end else begin
            st_q <= st_d; glb_q <= glb_d; cache_q <= cache_d; poll_q <= poll_d; op_q <= op_d;
            addr_q <= addr_d; count_q <= count_d; nop_q <= nop_d; irq_q <= irq_d; refused_q <= refused_d;
            rqv_q <= rqv_d; rqw_q <= rqw_d; rqi_q <= rqi_d; rqd_q <= rqd_d;
            awg_q <= awg_d; wg_q <= wg_d; awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
            bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
        end
    end

    assign AWREADY       = ~awg_q & ~bv_q;
    assign WREADY        = ~wg_q & ~bv_q;
    assign BVALID        = bv_q;
    assign BRESP         = br_q;
    assign ARREADY       = ~rv_q;
    assign RVALID        = rv_q;
    assign RDATA         = rd_q;
    assign RRESP         = rr_q;
    assign IRQ_EN        = irq_q;
    // whole sequence, tail included, keeps the memory system quiet
    assign MEM_GRANT     = MEM_REQ & (st_q == S_IDLE); // R03
    assign bus.rq_valid  = rqv_q;
    assign bus.rq_write  = rqw_q;
    assign bus.rq_index  = rqi_q;
    assign bus.rq_wdata  = rqd_q;
    assign bus.fence_req = st_q == S_WAIT; // R08
endmodule

// ==== cc_engine.sv ====
// cache coherence engine: block and global operations for the level-1 data and level-2 caches
// Summary of operation
// R01: no allocation between invalidate and its completion
// R02: writeback-only operations never hold allocation
// R03: core keeps memory idle during operations
// R04: core disables interrupts, writes base, then count
// R05: count write launches; count reads zero when done
// R06: writing one to trigger launches global operation
// R07: trigger bit zero reads one until finished
// R08: core waits, sixteen idle cycles, reenables interrupts
// R09: fence stalls until coherence work completes
// R10: busy cache refuses new operation
`timescale 1ns/1ns
module cc_engine #(
    parameter int NUM_SETS = 256,
    parameter int SET_W    = 8
) (
    input  wire logic                                 CLK,        // core clock
    input  wire logic                                 SRST,       // synchronous reset, active high
    cc_if.cache                                       bus,        // command link from the core
    output logic      [cc_pkg::NUM_CACHES-1:0]        CMD_VALID,  // per cache: step command offered
    input  wire logic [cc_pkg::NUM_CACHES-1:0]        CMD_READY,  // per cache: step done by the array
    output logic      [cc_pkg::NUM_CACHES-1:0]        CMD_GLOBAL, // per cache: step is by set, not address
    output logic      [2*cc_pkg::NUM_CACHES-1:0]      CMD_OP,     // per cache: operation kind
    output logic      [cc_pkg::NUM_CACHES*cc_pkg::ADDR_W-1:0] CMD_ADDR, // per cache: line address
    output logic      [cc_pkg::NUM_CACHES*SET_W-1:0]  CMD_SET,    // per cache: set number
    output logic                                      ALLOC_HOLD  // stall cache line allocation
);
    localparam int LINE_WORDS = cc_pkg::LINE_BYTES / cc_pkg::WORD_BYTES;

    if (NUM_SETS < 2 || NUM_SETS > (1 << SET_W)) begin : g_chk
        $error("NUM_SETS does not fit SET_W");
    end
    if (LINE_WORDS < 1 || LINE_WORDS >= (1 << cc_pkg::WC_W)) begin : g_chk_line
        $error("line size does not fit the word counter");
    end

    typedef enum logic [2:0] {
        S_IDLE   = 3'b001,
        S_BLOCK  = 3'b010,
        S_GLOBAL = 3'b100
    } eng_e;

    eng_e                        st_q  [cc_pkg::NUM_CACHES];
    logic [cc_pkg::ADDR_W-1:0]   bar_q [cc_pkg::NUM_CACHES];
    logic [cc_pkg::WC_W-1:0]     wc_q  [cc_pkg::NUM_CACHES];
    logic [1:0]                  op_q  [cc_pkg::NUM_CACHES];
    logic [SET_W-1:0]            set_q [cc_pkg::NUM_CACHES];
    logic [cc_pkg::NUM_CACHES-1:0] busy;
    logic [cc_pkg::NUM_CACHES-1:0] hold;

    logic                        take;
    logic                        wr;
    logic [cc_pkg::IDX_W-1:0]    idx;

    // writes are taken at once; the link never waits on the engine
    assign bus.rq_ready = 1'b1;
    assign take         = bus.rq_valid & bus.rq_ready;
    assign wr           = take & bus.rq_write;
    assign idx          = bus.rq_index;

    for (genvar c = 0; c < cc_pkg::NUM_CACHES; c++) begin : g_cache
        localparam logic [cc_pkg::IDX_W-1:0] BAR_IDX = (c == 0) ? cc_pkg::IDX_BAR_L1 : cc_pkg::IDX_BAR_L2;
        localparam logic [cc_pkg::IDX_W-1:0] GLB_IDX = (c == 0) ? cc_pkg::IDX_GLB_L1 : cc_pkg::IDX_GLB_L2;

        eng_e                      st_d;
        logic [cc_pkg::ADDR_W-1:0] bar_d;
        logic [cc_pkg::WC_W-1:0]   wc_d;
        logic [1:0]                op_d;
        logic [SET_W-1:0]          set_d;
        logic                      wr_bar;
        logic                      wr_wc;
        logic                      wr_glb;
        logic [1:0]                wc_op;
        logic [1:0]                glb_op;

        assign wc_op  = 2'(idx - BAR_IDX - 4'h1);
        assign glb_op = 2'(idx - GLB_IDX);
        assign wr_bar = wr && idx == BAR_IDX;
        assign wr_wc  = wr && idx > BAR_IDX && idx <= BAR_IDX + 4'h3;
        assign wr_glb = wr && idx >= GLB_IDX && idx <= GLB_IDX + 4'h2;

        always_comb begin
            st_d  = st_q[c];
            bar_d = bar_q[c];
            wc_d  = wc_q[c];
            op_d  = op_q[c];
            set_d = set_q[c];
            case (st_q[c])
                S_IDLE: begin
                    // new orders are taken only while this cache is idle
                    if (wr_bar) begin
                        bar_d = bus.rq_wdata[cc_pkg::ADDR_W-1:0]; // R04
                    end
                    if (wr_wc) begin
                        wc_d = bus.rq_wdata[cc_pkg::WC_W-1:0];
                        op_d = wc_op;
                        if (bus.rq_wdata[cc_pkg::WC_W-1:0] != '0) begin
                            st_d = S_BLOCK; // R05
                        end
                    end else if (wr_glb && bus.rq_wdata[cc_pkg::TRIG_BIT]) begin
                        op_d  = glb_op;
                        set_d = '0;
                        st_d  = S_GLOBAL; // R06
                    end
                end
                S_BLOCK: begin
                    if (CMD_READY[c]) begin
                        bar_d = bar_q[c] + cc_pkg::ADDR_W'(cc_pkg::LINE_BYTES);
                        if (wc_q[c] > cc_pkg::WC_W'(LINE_WORDS)) begin
                            wc_d = wc_q[c] - cc_pkg::WC_W'(LINE_WORDS);
                        end else begin
                            wc_d = '0; // R05
                            st_d = S_IDLE;
                        end
                    end
                end
                S_GLOBAL: begin
                    if (CMD_READY[c]) begin
                        if (set_q[c] == SET_W'(NUM_SETS - 1)) begin
                            st_d = S_IDLE; // R07
                        end else begin
                            set_d = set_q[c] + SET_W'(1);
                        end
                    end
                end
                default: begin
                    st_d = S_IDLE;
                end
            endcase
        end

        always_ff @(posedge CLK) begin
            if (SRST) begin
                st_q[c]  <= S_IDLE;
                bar_q[c] <= '0;
                wc_q[c]  <= '0;
                op_q[c]  <= cc_pkg::OP_WB;
                set_q[c] <= '0;
            end else begin
                st_q[c]  <= st_d; // R10
                bar_q[c] <= bar_d;
                wc_q[c]  <= wc_d;
                op_q[c]  <= op_d;
                set_q[c] <= set_d;
            end
        end

        assign busy[c] = st_q[c] != S_IDLE;
        // writeback-only work leaves the set contents intact, so allocation may go on
        assign hold[c] = busy[c] && op_q[c] != cc_pkg::OP_WB; // R02

        assign CMD_VALID[c]                                  = busy[c];
        assign CMD_GLOBAL[c]                                 = st_q[c] == S_GLOBAL;
        assign CMD_OP[2*c +: 2]                              = op_q[c];
        assign CMD_ADDR[c*cc_pkg::ADDR_W +: cc_pkg::ADDR_W]  = bar_q[c];
        assign CMD_SET[c*SET_W +: SET_W]                     = set_q[c];
    end

    // allocation waits for any invalidating sweep in either the level-1 or the level-2 cache
    assign ALLOC_HOLD     = |hold; // R01
    assign bus.fence_done = ~|busy; // R09

    // read path
    logic                      rs_valid_d;
    logic                      rs_valid_q;
    logic [cc_pkg::DATA_W-1:0] rs_rdata_d;
    logic [cc_pkg::DATA_W-1:0] rs_rdata_q;
    logic                      rd_cache;
    logic [1:0]                rd_op;

    always_comb begin
        rs_valid_d = take & ~bus.rq_write;
        rs_rdata_d = rs_rdata_q;
        rd_cache   = 1'b0;
        rd_op      = cc_pkg::OP_WB;
        if (take && !bus.rq_write) begin
            rs_rdata_d = '0;
            if (idx < cc_pkg::IDX_GLB_L1) begin
                rd_cache = idx >= cc_pkg::IDX_BAR_L2;
                rd_op    = 2'(idx[1:0] - 2'h1);
                if (idx[1:0] == 2'h0) begin
                    rs_rdata_d[cc_pkg::ADDR_W-1:0] = bar_q[rd_cache];
                end else if (st_q[rd_cache] == S_BLOCK && op_q[rd_cache] == rd_op) begin
                    rs_rdata_d[cc_pkg::WC_W-1:0] = wc_q[rd_cache]; // R05
                end
            end else if (idx < cc_pkg::IDX_BUSY) begin
                rd_cache = idx >= cc_pkg::IDX_GLB_L2;
                rd_op    = rd_cache ? 2'(idx - cc_pkg::IDX_GLB_L2) : 2'(idx - cc_pkg::IDX_GLB_L1);
                rs_rdata_d[cc_pkg::TRIG_BIT] = st_q[rd_cache] == S_GLOBAL && op_q[rd_cache] == rd_op; // R07
            end else if (idx == cc_pkg::IDX_BUSY) begin
                rs_rdata_d[cc_pkg::NUM_CACHES-1:0] = busy;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rs_valid_q <= 1'b0;
            rs_rdata_q <= '0;
        end else begin
            rs_valid_q <= rs_valid_d;
            rs_rdata_q <= rs_rdata_d;
        end
    end

    assign bus.rs_valid = rs_valid_q;
    assign bus.rs_rdata = rs_rdata_q;
endmodule

// ==== cc_if.sv ====
// command link between the issuing core and the cache coherence engine
`timescale 1ns/1ns
interface cc_if;
    logic                        rq_valid;   // register request offered
    logic                        rq_ready;   // request taken
    logic                        rq_write;   // 1 write, 0 read
    logic [cc_pkg::IDX_W-1:0]    rq_index;   // register index
    logic [cc_pkg::DATA_W-1:0]   rq_wdata;   // write data
    logic                        rs_valid;   // read answer pulse
    logic [cc_pkg::DATA_W-1:0]   rs_rdata;   // read answer data
    logic                        fence_req;  // memory fence pending in core
    logic                        fence_done; // no coherence work outstanding

    modport core (
        output rq_valid, rq_write, rq_index, rq_wdata, fence_req,
        input  rq_ready, rs_valid, rs_rdata, fence_done
    );
    modport cache (
        input  rq_valid, rq_write, rq_index, rq_wdata, fence_req,
        output rq_ready, rs_valid, rs_rdata, fence_done
    );
endinterface

// ==== cc_pkg.sv ====
// shared constants for the cache coherence command link and its control registers
package cc_pkg;
    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 32;
    localparam int IDX_W      = 4;
    localparam int WC_W       = 16;
    localparam int NOP_CYCLES = 16;
    localparam int NOP_W      = 5;
    localparam int LINE_BYTES = 64;
    localparam int WORD_BYTES = 4;
    localparam int NUM_CACHES = 2;

    // coherence operation kinds
    localparam logic [1:0] OP_WB    = 2'h0;
    localparam logic [1:0] OP_INV   = 2'h1;
    localparam logic [1:0] OP_WBINV = 2'h2;

    // device register indices: per cache a base address, then one word count per kind
    localparam logic [IDX_W-1:0] IDX_BAR_L1 = 4'h0;
    localparam logic [IDX_W-1:0] IDX_BAR_L2 = 4'h4;
    // global triggers: one per kind, level-1 group then level-2 group
    localparam logic [IDX_W-1:0] IDX_GLB_L1 = 4'h8;
    localparam logic [IDX_W-1:0] IDX_GLB_L2 = 4'hb;
    localparam logic [IDX_W-1:0] IDX_BUSY   = 4'he;
    localparam int               TRIG_BIT   = 0;

    // controller registers on AXI4-Lite (byte offsets)
    localparam int               AXI_AW     = 6;
    localparam logic [AXI_AW-1:0] A_CTRL    = 6'h00;
    localparam logic [AXI_AW-1:0] A_ADDR    = 6'h04;
    localparam logic [AXI_AW-1:0] A_COUNT   = 6'h08;
    localparam logic [AXI_AW-1:0] A_STATUS  = 6'h0c;
    // control register fields
    localparam int CTRL_GO     = 0;
    localparam int CTRL_GLOBAL = 1;
    localparam int CTRL_CACHE  = 2;
    localparam int CTRL_OP_LSB = 3;
    localparam int CTRL_POLL   = 5;
    // status register fields
    localparam int ST_BUSY     = 0;
    localparam int ST_IRQ_EN   = 1;
    localparam int ST_REFUSED  = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
